/* rtl/scwm_mapper.sv */
// status and control word mapper with apb register access
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module scwm_mapper
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin4_in,
  input wire logic [7:0] pin2_in,
  input wire logic [7:0] port_fault,
  output logic [7:0] pin4_out,
  output logic [7:0] pin2_out,
  output logic [15:0] status_word
);

  // ==========================================================
  // helper functions

  function automatic logic [15:0] swap_bytes(input logic [15:0] w);
    swap_bytes = {w[7:0], w[15:8]};
  endfunction

  // builds {Bn,An,...} for four ports starting at base
  function automatic logic [7:0] interleave
  (
    input logic [7:0] a,
    input logic [7:0] b,
    input int base
  );
    interleave = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      interleave[2 * i] = a[base + i];
      interleave[2 * i + 1] = b[base + i];
    end
  endfunction

  // ==========================================================
  // registers

  logic [2:0] config_q;
  logic [7:0] mode_a_q;
  logic [7:0] mode_b_q;
  logic [15:0] ctrl_word_q;
  logic [7:0] subslot_out_q;
  logic run_q;
  logic [15:0] in_s1_q;
  logic [15:0] in_s2_q;
  logic [15:0] in_s3_q;
  logic [15:0] in_filt_q;
  logic [7:0] pin4_out_q;
  logic [7:0] pin2_out_q;
  logic [15:0] status_q;
  logic [7:0] fault_s1_q;
  logic [7:0] fault_s2_q;
  logic [7:0] fault_s3_q;
  logic [7:0] fault_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ==========================================================
  // pin input and port fault synchronisers

  // a change is only taken once the second and third stages agree
  wire logic [15:0] in_agree = ~(in_s2_q ^ in_s3_q);
  wire logic [15:0] in_filt_d = (in_s2_q & in_agree) |
    (in_filt_q & ~in_agree);
  wire logic [7:0] fault_agree = ~(fault_s2_q ^ fault_s3_q);
  wire logic [7:0] fault_d = (fault_s2_q & fault_agree) |
    (fault_q & ~fault_agree);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_s1_q <= 16'h0000;
      in_s2_q <= 16'h0000;
      in_s3_q <= 16'h0000;
      in_filt_q <= 16'h0000;
    end
    else
    begin
      in_s1_q <= {pin2_in, pin4_in};
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      in_filt_q <= in_filt_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_s1_q <= 8'h00;
      fault_s2_q <= 8'h00;
      fault_s3_q <= 8'h00;
      fault_q <= 8'h00;
    end
    else
    begin
      fault_s1_q <= port_fault;
      fault_s2_q <= fault_s1_q;
      fault_s3_q <= fault_s2_q;
      fault_q <= fault_d;
    end
  end

  wire logic [7:0] a_in = in_filt_q[7:0];
  wire logic [7:0] b_in = in_filt_q[15:8];

  // ==========================================================
  // settings

  wire logic retrofit = config_q[scwm_pkg::CFG_LAYOUT_BIT];
  wire logic swapped = config_q[scwm_pkg::CFG_SWAP_BIT];
  wire logic src_word = config_q[scwm_pkg::CFG_SOURCE_BIT];
  wire logic [7:0] a_is_out = mode_a_q;
  wire logic [7:0] b_is_out = mode_b_q & scwm_pkg::B_OUT_CAPABLE;

  // ==========================================================
  // status word assembly

  // output channels report the driven level, inputs the pin
  wire logic [7:0] a_stat = (pin4_out_q & a_is_out) |
    (a_in & ~a_is_out);
  wire logic [7:0] b_stat = (pin2_out_q & b_is_out) |
    (b_in & ~b_is_out);

  wire logic [15:0] stat_default = {interleave(a_stat, b_stat, 0),
    interleave(a_stat, b_stat, 4)};
  wire logic [15:0] stat_retro = {a_stat, b_stat};
  wire logic [15:0] stat_order1 = retrofit ? stat_retro : stat_default;
  wire logic [15:0] status_d = swapped ? swap_bytes(stat_order1) :
    stat_order1;

  // ==========================================================
  // control word decode

  // bring the word to the order-one layout before picking bits
  wire logic [15:0] cw = swapped ? swap_bytes(ctrl_word_q) :
    ctrl_word_q;
  wire logic [7:0] cw_hi = cw[15:8];
  wire logic [7:0] cw_lo = cw[7:0];

  // default layout: A8 has a slot only in order two
  wire logic [7:0] dflt_a_valid = {swapped, 7'h7F};
  wire logic [7:0] dflt_a = {swapped ? cw_lo[6] : 1'b0,
    cw_lo[4], cw_lo[2], cw_lo[0], cw_hi[6], cw_hi[4], cw_hi[2],
    cw_hi[0]};
  wire logic [3:0] dflt_b = {cw_lo[7], cw_lo[5], cw_lo[3],
    cw_lo[1]};

  wire logic [7:0] retro_a = cw_hi;
  wire logic [3:0] retro_b = cw_lo[7:4];

  wire logic [7:0] word_a = retrofit ? retro_a : dflt_a;
  wire logic [7:0] word_a_valid = retrofit ? 8'hFF : dflt_a_valid;
  wire logic [7:0] word_b = {retrofit ? retro_b : dflt_b, 4'h0};

  // ==========================================================
  // output drive

  // per A channel a single mux picks the source, never an or; B always takes the word
  wire logic [7:0] a_from_word = {8{src_word}} & word_a_valid;
  wire logic [7:0] a_level = (word_a & a_from_word) |
    (subslot_out_q & ~a_from_word);
  wire logic [7:0] pin4_out_d = a_level & a_is_out;
  wire logic [7:0] pin2_out_d = word_b & b_is_out;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin4_out_q <= 8'h00;
      pin2_out_q <= 8'h00;
      status_q <= 16'h0000;
    end
    else
    begin
      pin4_out_q <= pin4_out_d;
      pin2_out_q <= pin2_out_d;
      status_q <= status_d;
    end
  end

  // ==========================================================
  // sub-slot input byte and diagnostics

  // bit n is bit 0 of the input byte of port n+1
  wire logic [7:0] subslot_in = a_in & ~a_is_out;

  // lowest faulty port number; zero means no fault
  logic [3:0] diag_chan;
  always_comb
  begin
    diag_chan = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (fault_q[i])
      begin
        diag_chan = 4'(i + 1);
      end
    end
  end

  // ==========================================================
  // apb decode

  wire logic access = psel && penable && !pready_q;
  wire logic hit_config = paddr == scwm_pkg::OFS_CONFIG;
  wire logic hit_mode = paddr == scwm_pkg::OFS_PORT_MODE;
  wire logic hit_ctrl = paddr == scwm_pkg::OFS_CTRL_WORD;
  wire logic hit_sub_out = paddr == scwm_pkg::OFS_SUBSLOT_OUT;
  wire logic hit_status = paddr == scwm_pkg::OFS_STATUS_WORD;
  wire logic hit_sub_in = paddr == scwm_pkg::OFS_SUBSLOT_IN;
  wire logic hit_exch = paddr == scwm_pkg::OFS_EXCHANGE;
  wire logic hit_diag = paddr == scwm_pkg::OFS_DIAG;
  wire logic hit_any = hit_config || hit_mode || hit_ctrl ||
    hit_sub_out || hit_status || hit_sub_in || hit_exch || hit_diag;

  // settings are frozen while cyclic exchange runs
  wire logic cfg_locked = run_q && (hit_config || hit_mode);
  wire logic read_only = hit_status || hit_sub_in || hit_diag;
  wire logic wr_ok = access && pwrite && hit_any && !cfg_locked &&
    !read_only;
  wire logic err_d = !hit_any || (pwrite && (cfg_locked || read_only));

  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_config)
    begin
      rd_data = {29'h0, config_q};
    end
    else if (hit_mode)
    begin
      rd_data = {16'h0, mode_b_q, mode_a_q};
    end
    else if (hit_ctrl)
    begin
      rd_data = {16'h0, ctrl_word_q};
    end
    else if (hit_sub_out)
    begin
      rd_data = {24'h0, subslot_out_q};
    end
    else if (hit_status)
    begin
      rd_data = {16'h0, status_q};
    end
    else if (hit_sub_in)
    begin
      rd_data = {24'h0, subslot_in};
    end
    else if (hit_exch)
    begin
      rd_data = {31'h0, run_q};
    end
    else if (hit_diag)
    begin
      rd_data = {20'h0, diag_chan, fault_q};
    end
  end

  // ==========================================================
  // register writes

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_q <= scwm_pkg::CONFIG_RST;
      mode_a_q <= scwm_pkg::PORT_MODE_A_RST;
      mode_b_q <= scwm_pkg::PORT_MODE_B_RST;
    end
    else if (wr_ok && hit_config)
    begin
      config_q <= pwdata[2:0];
    end
    else if (wr_ok && hit_mode)
    begin
      mode_a_q <= pwdata[scwm_pkg::MODE_A_LSB +: 8];
      mode_b_q <= pwdata[scwm_pkg::MODE_B_LSB +: 8];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_word_q <= scwm_pkg::CTRL_WORD_RST;
      subslot_out_q <= scwm_pkg::SUBSLOT_OUT_RST;
      run_q <= 1'b0;
    end
    else if (wr_ok && hit_ctrl)
    begin
      ctrl_word_q <= pwdata[15:0];
    end
    else if (wr_ok && hit_sub_out)
    begin
      subslot_out_q <= pwdata[7:0];
    end
    else if (wr_ok && hit_exch)
    begin
      run_q <= pwdata[scwm_pkg::EXCH_RUN_BIT];
    end
  end

  // ==========================================================
  // apb response: one wait state, then pready for one cycle

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= access;
      pslverr_q <= access && err_d;
      prdata_q <= (access && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin4_out = pin4_out_q;
  assign pin2_out = pin2_out_q;
  assign status_word = status_q;

endmodule

`default_nettype wire

/* rtl/scwm_pkg.sv */
// constants for the status and control word mapper
package scwm_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PORT_MODE = 8'h04;
  localparam logic [7:0] OFS_CTRL_WORD = 8'h08;
  localparam logic [7:0] OFS_SUBSLOT_OUT = 8'h0C;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h10;
  localparam logic [7:0] OFS_SUBSLOT_IN = 8'h14;
  localparam logic [7:0] OFS_EXCHANGE = 8'h18;
  localparam logic [7:0] OFS_DIAG = 8'h1C;

  // ==========================================================
  // field positions
  localparam int CFG_LAYOUT_BIT = 0;
  localparam int CFG_SWAP_BIT = 1;
  localparam int CFG_SOURCE_BIT = 2;
  localparam int EXCH_RUN_BIT = 0;
  localparam int MODE_A_LSB = 0;
  localparam int MODE_B_LSB = 8;
  localparam int DIAG_CHAN_LSB = 8;

  // ==========================================================
  // reset values
  localparam logic [2:0] CONFIG_RST = 3'h0;
  localparam logic [7:0] PORT_MODE_A_RST = 8'h00;
  localparam logic [7:0] PORT_MODE_B_RST = 8'h00;
  localparam logic [15:0] CTRL_WORD_RST = 16'h0000;
  localparam logic [7:0] SUBSLOT_OUT_RST = 8'h00;

  // only ports 5 to 8 have a channel-B output driver
  localparam logic [7:0] B_OUT_CAPABLE = 8'hF0;

  // ==========================================================
  // mode encodings
  typedef enum logic
  {
    LAYOUT_DEFAULT,
    LAYOUT_RETROFIT
  } scwm_layout_type;

  typedef enum logic
  {
    ORDER_ONE,
    ORDER_TWO
  } scwm_order_type;

  typedef enum logic
  {
    SRC_SUBSLOT,
    SRC_CTRL_WORD
  } scwm_source_type;

endpackage

/* verification/scwm_mapper_checker.sv */
// port assertions for the word mapper
`timescale 1ns/100ps
`default_nettype none
module scwm_mapper_checker
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pin4_in,
  input wire logic [7:0] pin2_in,
  input wire logic [7:0] port_fault,
  input wire logic [7:0] pin4_out,
  input wire logic [7:0] pin2_out,
  input wire logic [15:0] status_word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus steps
  sequence acc_start_s;
    psel && penable && !pready;
  endsequence
  sequence done_s;
    pready ##1 !pready;
  endsequence
  ready_after_wait_a: assert property ($rose(penable) && psel |=> done_s)
    else $error("pready late");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (acc_start_s ##0
    paddr > scwm_pkg::OFS_DIAG |=> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  ro_write_err_a: assert property (acc_start_s ##0 pwrite &&
    paddr == scwm_pkg::OFS_STATUS_WORD |=> pslverr)
    else $error("status write not refused");
  // ports 1 to 4 have no channel-B driver, so their bits must stay low
  b_low_off_a: assert property (
    (pin2_out & ~scwm_pkg::B_OUT_CAPABLE) == 8'h00)
    else $error("pin2_out low ports driven");
  out_after_write_a: assert property ($changed(pin4_out) || $changed(pin2_out)
    |-> $past(pready && pwrite))
    else $error("outputs moved without write");
endmodule

bind scwm_mapper scwm_mapper_checker u_scwm_mapper_checker (.clk_sys(clk_sys),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin4_in(pin4_in), .pin2_in(pin2_in),
  .port_fault(port_fault), .pin4_out(pin4_out), .pin2_out(pin2_out),
  .status_word(status_word));
`default_nettype wire

/* verification/scwm_mapper_tb_top.sv */
// self-checking bench for the word mapper
`timescale 1ns/100ps
`default_nettype none
module scwm_mapper_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_b = 8'h00;
  logic [7:0] port_fault = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin4_in;
  logic [7:0] pin2_in;
  logic [7:0] pin4_out;
  logic [7:0] pin2_out;
  logic [15:0] status_word;
  logic [15:0] eo;
  int fails = 0;
  int total_checks = 0;

  always #10 clk_sys = ~clk_sys;

  scwm_mapper u_scwm_mapper (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin4_in(pin4_in),
    .pin2_in(pin2_in), .port_fault(port_fault), .pin4_out(pin4_out),
    .pin2_out(pin2_out), .status_word(status_word));
  scwm_pin_model u_scwm_pin_model (.ext_a(ext_a), .ext_b(ext_b),
    .pin4_out(pin4_out), .pin2_out(pin2_out), .pin4_in(pin4_in),
    .pin2_in(pin2_in));

  // ==========================================================
  // checking and verdict
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // apb master; request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] ed, input logic ee);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready));
    chk("pslverr", 32'(ee), 32'(pslverr));
    if (!w)
      chk("prdata", ed, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // expected layouts
  function automatic logic [15:0] st(logic [2:0] c, logic [7:0] a,
    logic [7:0] b);
    logic [15:0] u;
    for (int i = 0; i < 4; i++)
    begin
      u[8+2*i] = a[i];
      u[9+2*i] = b[i];
      u[2*i] = a[4+i];
      u[2*i+1] = b[4+i];
    end
    if (c[0])
      u = {a, b};
    return c[1] ? {u[7:0], u[15:8]} : u;
  endfunction

  // returns {pin4_out, pin2_out}
  function automatic logic [15:0] oe(logic [2:0] c, logic [15:0] w,
    logic [7:0] s, logic [15:0] m);
    logic [15:0] u;
    logic [7:0] ac;
    logic [7:0] bc;
    logic [7:0] has;
    u = c[1] ? {w[7:0], w[15:8]} : w;
    has = {c[1], 7'h7F};
    for (int i = 0; i < 4; i++)
    begin
      ac[i] = u[8+2*i];
      ac[4+i] = u[2*i];
      bc[i] = 1'b0;
      bc[4+i] = u[2*i+1];
    end
    if (c[0])
    begin
      ac = u[15:8];
      has = 8'hFF;
      bc = {u[7:4], 4'h0};
    end
    if (c[2])
      s = (ac & has) | (s & ~has);
    return {m[7:0] & s, m[15:8] & bc & scwm_pkg::B_OUT_CAPABLE};
  endfunction

  // ==========================================================
  // tests
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, scwm_pkg::OFS_CONFIG, 32'h0, 32'h0, 1'b0);
    ext_a <= 8'hA5;
    ext_b <= 8'h3C;
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, scwm_pkg::OFS_CONFIG, 32'(c), 32'h0, 1'b0);
      repeat (6) @(posedge clk_sys);
      chk("status", 32'(st(c[2:0], 8'hA5, 8'h3C)), 32'(status_word));
      apb(1'b0, scwm_pkg::OFS_SUBSLOT_IN, 32'h0, 32'hA5, 1'b0);
    end
    ext_a <= 8'h01;
    ext_b <= 8'h0F;
    apb(1'b1, scwm_pkg::OFS_PORT_MODE, 32'hFFFE, 32'h0, 1'b0);
    apb(1'b1, scwm_pkg::OFS_CTRL_WORD, 32'hA5C3, 32'h0, 1'b0);
    apb(1'b1, scwm_pkg::OFS_SUBSLOT_OUT, 32'hBC, 32'h0, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, scwm_pkg::OFS_CONFIG, 32'(c), 32'h0, 1'b0);
      repeat (6) @(posedge clk_sys);
      eo = oe(c[2:0], 16'hA5C3, 8'hBC, 16'hFFFE);
      chk("pin4_out", 32'(eo[15:8]), 32'(pin4_out));
      chk("pin2_out", 32'(eo[7:0]), 32'(pin2_out));
      eo = st(c[2:0], eo[15:8] | 8'h01, eo[7:0] | 8'h0F);
      chk("status", 32'(eo), 32'(status_word));
    end
    apb(1'b1, scwm_pkg::OFS_EXCHANGE, 32'h1, 32'h0, 1'b0);
    apb(1'b1, scwm_pkg::OFS_CONFIG, 32'h0, 32'h0, 1'b1);
    apb(1'b0, scwm_pkg::OFS_CONFIG, 32'h0, 32'h7, 1'b0);
    apb(1'b1, scwm_pkg::OFS_EXCHANGE, 32'h0, 32'h0, 1'b0);
    apb(1'b1, scwm_pkg::OFS_STATUS_WORD, 32'hFFFF, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    port_fault <= 8'h28;
    repeat (6) @(posedge clk_sys);
    apb(1'b0, scwm_pkg::OFS_DIAG, 32'h0, 32'h428, 1'b0);
    // second reset in mid-run must bring back the default settings
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, scwm_pkg::OFS_CONFIG, 32'h0, 32'h0, 1'b0);
    apb(1'b0, scwm_pkg::OFS_PORT_MODE, 32'h0, 32'h0, 1'b0);
    chk("pin4_out", 32'h0, 32'(pin4_out));
    tally_and_finish;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* verification/scwm_pin_model.sv */
// pin side model: field levels wired-or with the device drive
`timescale 1ns/100ps
`default_nettype none
module scwm_pin_model
(
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] pin4_out,
  input wire logic [7:0] pin2_out,
  output logic [7:0] pin4_in,
  output logic [7:0] pin2_in
);
  // a driven pin reads back its drive on top of the field level
  assign pin4_in = ext_a | pin4_out;
  assign pin2_in = ext_b | pin2_out;
endmodule
`default_nettype wire
